// ===== xcvr_pkg.sv
// Shared constants, register map and carrier types for the quad bus transceiver
package xcvr_pkg;

  localparam int DATA_W = 4;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  // Register byte addresses
  localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] ADDR_PORTS = 12'h008;

  // Control register fields, high bit first in the word
  typedef struct packed {
    logic output_control_n;
    logic receiver_latch_control_n;
    logic bus_drive_control_n;
    logic source_select;
  } ctrl_s;

  localparam int CTRL_W = $bits(ctrl_s);

  // Drivers released, latch open, receiver outputs off, port A selected
  localparam ctrl_s CTRL_RESET = 4'hA;

  // Status word: latched receiver data, sensed bus, driver register
  typedef struct packed {
    logic [DATA_W-1:0] rx_latched;
    logic [DATA_W-1:0] bus_level;
    logic [DATA_W-1:0] driver_bits;
  } status_s;

  localparam int STATUS_W = $bits(status_s);

  // Port readback word: port B above port A
  typedef struct packed {
    logic [DATA_W-1:0] port_b;
    logic [DATA_W-1:0] port_a;
  } ports_s;

  localparam int PORTS_W = $bits(ports_s);

  localparam logic [DATA_W-1:0] DATA_ZERO = 4'h0;
  localparam logic [APB_DW-1:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ===== rx_latch_bank.sv
// Receiver latch bank: one level-controlled latch per bus line
`timescale 1ns/100ps
`default_nettype none

module rx_latch_bank
  import xcvr_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic latch_open,
  input wire logic [W-1:0] bus_level,
  output logic [W-1:0] q
);

  genvar i;

  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Open: follow the inverted line; closed: keep the captured bit
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          q[i] <= 1'b0;
        end else if (ce && latch_open) begin
          q[i] <= ~bus_level[i];
        end
      end
    end
  endgenerate

  chk_latch_shared: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && latch_open |=> q == ~$past(bus_level)
  ) else $error("latch bank did not follow the inverted bus");

  chk_latch_closed: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(ce && latch_open) |=> $stable(q)
  ) else $error("closed latch bank changed");

endmodule

`default_nettype wire

// ===== quad_bus_transceiver_registered.sv
// Quad registered open-collector bus transceiver with APB control
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module quad_bus_transceiver_registered
  import xcvr_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [W-1:0] port_a,
  input wire logic [W-1:0] port_b,
  input wire logic driver_register_clock,
  input wire logic [W-1:0] bus_in,
  output logic [W-1:0] bus_out,
  output logic [W-1:0] bus_oe,
  output logic [W-1:0] rx_data,
  output logic [W-1:0] rx_oe
);

  ctrl_s ctrl_q;
  logic [W-1:0] driver_q;
  logic [W-1:0] driver_d;
  logic drv_clk_prev_q;
  logic drv_clk_rise;
  logic [W-1:0] rx_latched;
  logic setup_phase;
  logic access_done;
  logic wr_ctrl;
  logic [APB_DW-1:0] rdata_d;
  logic addr_err;
  status_s status_word;
  ports_s ports_word;

  // ---------------- APB slave ----------------

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_ctrl = access_done && pwrite && (paddr == ADDR_CTRL);

  assign status_word = '{rx_latched: rx_latched, bus_level: bus_in, driver_bits: driver_q};
  assign ports_word = '{port_b: port_b, port_a: port_a};

  // Read data and error are decided in the setup cycle
  always_comb begin
    rdata_d = WORD_ZERO;
    addr_err = 1'b0;
    if (paddr == ADDR_CTRL) begin
      rdata_d[CTRL_W-1:0] = ctrl_q;
    end else if (paddr == ADDR_STATUS) begin
      rdata_d[STATUS_W-1:0] = status_word;
    end else if (paddr == ADDR_PORTS) begin
      rdata_d[PORTS_W-1:0] = ports_word;
    end else begin
      addr_err = 1'b1;
    end
  end

  // One wait-free access phase: ready rises for the cycle after setup
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= WORD_ZERO;
    end else if (ce) begin
      if (setup_phase && !pwrite) begin
        prdata <= rdata_d;
      end else if (access_done) begin
        prdata <= WORD_ZERO;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setup_phase) begin
        pslverr <= addr_err;
      end else if (access_done) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (ce && wr_ctrl) begin
      ctrl_q <= ctrl_s'(pwdata[CTRL_W-1:0]);
    end
  end

  // ---------------- Driver register ----------------

  // The driver clock pin is sampled; its rising transition is the load event
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drv_clk_prev_q <= 1'b0;
    end else if (ce) begin
      drv_clk_prev_q <= driver_register_clock;
    end
  end

  assign drv_clk_rise = driver_register_clock && !drv_clk_prev_q;

  assign driver_d = ctrl_q.source_select ? port_b : port_a;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      driver_q <= DATA_ZERO;
    end else if (ce && drv_clk_rise) begin
      driver_q <= driver_d;
    end
  end

  // ---------------- Line drivers ----------------

  // Open-collector: the output level is always low, only the enable moves
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_out <= DATA_ZERO;
    end else if (ce) begin
      bus_out <= DATA_ZERO;
    end
  end

  // A one bit pulls its line low, so the line shows the inverse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_oe <= DATA_ZERO;
    end else if (ce) begin
      if (ctrl_q.bus_drive_control_n) begin
        bus_oe <= DATA_ZERO;
      end else begin
        bus_oe <= driver_q;
      end
    end
  end

  // ---------------- Receiver ----------------

  // bus_in is the resolved line, so own drive is seen as well
  rx_latch_bank #(
    .W(W)
  ) u_rx_latch (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .latch_open(!ctrl_q.receiver_latch_control_n),
    .bus_level(bus_in),
    .q(rx_latched)
  );

  assign rx_data = rx_latched;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_oe <= DATA_ZERO;
    end else if (ce) begin
      rx_oe <= {W{!ctrl_q.output_control_n}};
    end
  end

  // ---------------- Checks ----------------

  chk_load_port_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && drv_clk_rise && !ctrl_q.source_select |=> driver_q == $past(port_a)
  ) else $error("driver register did not load port A");

  chk_load_port_b: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && drv_clk_rise && ctrl_q.source_select |=> driver_q == $past(port_b)
  ) else $error("driver register did not load port B");

  chk_driver_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(ce && drv_clk_rise) |=> $stable(driver_q)
  ) else $error("driver register changed without a clock rise");

  chk_bus_released: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && ctrl_q.bus_drive_control_n |=> bus_oe == DATA_ZERO
  ) else $error("line drivers active while drive control high");

  chk_open_collector: assert property (
    @(posedge clock) disable iff (!rst_n)
    bus_out == DATA_ZERO
  ) else $error("line driver drove a high level");

  chk_bus_inverse: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && !ctrl_q.bus_drive_control_n |=> bus_oe == $past(driver_q)
  ) else $error("line enables do not match driver bits");

  chk_rx_follow: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && !ctrl_q.receiver_latch_control_n ##1 ce && !ctrl_q.receiver_latch_control_n
    |=> rx_data == ~$past(bus_in)
  ) else $error("receiver output not following inverted bus");

  chk_rx_own_loop: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && !ctrl_q.receiver_latch_control_n && (bus_in == ~driver_q)
    |=> rx_data == $past(driver_q)
  ) else $error("own driven data did not return in true polarity");

  chk_rx_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    ctrl_q.receiver_latch_control_n |=> $stable(rx_data)
  ) else $error("closed latch passed a bus change");

  chk_rx_enable: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce |=> rx_oe == {W{!$past(ctrl_q.output_control_n)}}
  ) else $error("receiver enable does not match output control");

  chk_apb_ready: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && setup_phase |=> pready
  ) else $error("APB access phase without ready");

  cov_load_b: cover property (
    @(posedge clock) disable iff (!rst_n)
    ce && drv_clk_rise && ctrl_q.source_select
  );

  cov_bus_driving: cover property (
    @(posedge clock) disable iff (!rst_n)
    !ctrl_q.bus_drive_control_n && (bus_oe != DATA_ZERO)
  );

  cov_latch_close: cover property (
    @(posedge clock) disable iff (!rst_n)
    !ctrl_q.receiver_latch_control_n ##1 ctrl_q.receiver_latch_control_n
  );

  cov_ctrl_write: cover property (
    @(posedge clock) disable iff (!rst_n)
    ce && wr_ctrl
  );

endmodule

`default_nettype wire

// ===== bus_agent_model.sv
// Other agents on the shared open-collector bus, with the line pull-up
`timescale 1ns/100ps
`default_nettype none

module bus_agent_model
  import xcvr_pkg::*;
(
  input wire logic [DATA_W-1:0] dut_out,
  input wire logic [DATA_W-1:0] dut_oe,
  input wire logic [DATA_W-1:0] pull,
  output logic [DATA_W-1:0] bus_level
);
  // A line is low if any agent sinks it, else the pull-up wins
  assign bus_level = ~((dut_oe & ~dut_out) | pull);
endmodule
`default_nettype wire

// ===== quad_bus_transceiver_registered_tb.sv
// Self-checking bench for the quad registered bus transceiver
`timescale 1ns/100ps
`default_nettype none

module quad_bus_transceiver_registered_tb;
  import xcvr_pkg::*;
  logic clock, rst_n, ce, psel, penable, pwrite, pready, pslverr, dclk, er;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [DATA_W-1:0] port_a, port_b, bus_in, bus_out, bus_oe, rx_data, rx_oe, pull;
  int bad_count, tests_run;
  int cycles = 0;

  quad_bus_transceiver_registered DUT (.clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a(port_a), .port_b(port_b),
    .driver_register_clock(dclk), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .rx_data(rx_data), .rx_oe(rx_oe));
  bus_agent_model agents (.dut_out(bus_out), .dut_oe(bus_oe), .pull(pull), .bus_level(bus_in));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task close_out;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      close_out;
    end
  end

  task chk_word(input logic [APB_DW-1:0] got, input logic [APB_DW-1:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_lines(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error at %0t: lines got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [APB_AW-1:0] addr, input logic [APB_DW-1:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Request stands until ready is seen at a rising edge; data is taken at that edge
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr_ctrl(input ctrl_s c);
    apb(1'b1, ADDR_CTRL, {28'h0000000, c});
  endtask

  task settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task dclk_pulse;
    @(posedge clock);
    dclk <= 1'b1;
    @(posedge clock);
    dclk <= 1'b0;
    settle(3);
  endtask

  task t_reset_regs;
    apb(1'b0, ADDR_CTRL, WORD_ZERO);
    chk_word(rd, 32'h0000000A);
    apb(1'b0, ADDR_PORTS, WORD_ZERO);
    chk_word(rd, 32'h000000A5);
    apb(1'b0, 12'hFFC, WORD_ZERO);
    chk_word({rd[30:0], er}, 32'h00000001);
    settle(1);
    chk_lines(bus_oe, 4'h0);
    chk_lines(rx_oe, 4'h0);
  endtask

  task t_drive_select;
    wr_ctrl(ctrl_s'(4'h0));
    dclk_pulse;
    chk_lines(bus_oe, 4'h5);
    chk_lines(bus_out, 4'h0);
    chk_lines(rx_data, 4'h5);
    chk_lines(rx_oe, 4'hF);
    apb(1'b0, ADDR_STATUS, WORD_ZERO);
    chk_word(rd, 32'h000005A5);
    wr_ctrl(ctrl_s'(4'h1));
    dclk_pulse;
    chk_lines(bus_oe, 4'hA);
    chk_lines(rx_data, 4'hA);
    @(posedge clock);
    port_b <= 4'h3;
    port_a <= 4'hC;
    settle(4);
    chk_lines(bus_oe, 4'hA);
  endtask

  task t_wired_release;
    @(posedge clock);
    pull <= 4'h9;
    settle(3);
    chk_lines(rx_data, 4'hB);
    wr_ctrl(ctrl_s'(4'h3));
    settle(3);
    chk_lines(bus_oe, 4'h0);
    chk_lines(rx_data, 4'h9);
  endtask

  task t_latch_hold;
    wr_ctrl(ctrl_s'(4'h6));
    pull <= 4'h6;
    settle(3);
    chk_lines(rx_data, 4'h9);
    chk_lines(rx_oe, 4'hF);
    wr_ctrl(ctrl_s'(4'h2));
    settle(3);
    chk_lines(rx_data, 4'h6);
    wr_ctrl(ctrl_s'(4'hA));
    settle(2);
    chk_lines(rx_oe, 4'h0);
  endtask

  // Clock enable low freezes the open latch although the bus moves
  task t_clock_enable;
    @(posedge clock);
    ce <= 1'b0;
    pull <= 4'h0;
    settle(3);
    chk_lines(rx_data, 4'h6);
    @(posedge clock);
    ce <= 1'b1;
    settle(2);
    chk_lines(rx_data, 4'h0);
  endtask

  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = ADDR_CTRL;
    pwdata = WORD_ZERO;
    port_a = 4'h5;
    port_b = 4'hA;
    dclk = 1'b0;
    pull = 4'h0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset_regs;
    t_drive_select;
    t_wired_release;
    t_latch_hold;
    t_clock_enable;
    close_out;
  end
endmodule
`default_nettype wire
